// ### core/ssw_pkg.sv
/*
 * ssw_pkg: constants, states and carriers of the supply supervisor and watchdog.
 * assumes a 100 MHz reference clock and a 1 ms tick derived from it.
 */
package ssw_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and tick
   localparam int unsigned CLK_PERIOD_NS = 10;          // reference clock period
   localparam int unsigned TICK_TIME_NS  = 1_000_000;   // one millisecond
   localparam int unsigned TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // timing figures in ms, and their tick counts
   localparam int unsigned RST_TIME_MS = 500;   // reset hold / pulse length
   localparam int unsigned WD_TIME_MS  = 700;   // watchdog timeout
   localparam int unsigned PB_TIME_MS  = 20;    // external pull debounce
   localparam int unsigned TICK_MS     = 1;
   localparam int unsigned CNT_W       = 10;    // wide enough for every count below
   localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RST_TIME_MS / TICK_MS - 1);
   localparam logic [CNT_W-1:0] WD_LAST  = CNT_W'(WD_TIME_MS / TICK_MS - 1);
   localparam logic [CNT_W-1:0] PB_LAST  = CNT_W'(PB_TIME_MS / TICK_MS - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;

   ////////////////////////////////////////////////////////////////////////////
   // supervisor states
   typedef enum logic [1:0] {
      SSW_POR   = 2'b00,   // supply low or settling after return
      SSW_RUN   = 2'b01,   // line released, watchdog counting
      SSW_PULSE = 2'b10    // watchdog or external reset pulse
   } ssw_state_e;

   ////////////////////////////////////////////////////////////////////////////
   // comparator flags, digital stand-ins for the analog detectors
   typedef struct packed {
      logic vcc_ok;          // main supply above trip level
      logic vcc_above_hi;    // main supply above battery plus 10 mV
      logic vcc_below_lo;    // main supply below battery minus 10 mV
      logic tdi_low;         // monitored input below 1.3 V
   } ssw_cmp_s;

endpackage

// ### core/ssw_tick.sv
/*
 * ssw_tick: divides the reference clock into a one-cycle 1 ms enable pulse.
 * assumes an asynchronous active-low reset already released cleanly.
 */
`timescale 1ns/1ps
module ssw_tick #(
   parameter int unsigned DIV = 100000     // clock cycles per tick
) (
   input  wire logic clk,                 // reference clock
   input  wire logic rst_n,               // synchronised reset
   output logic      tick                 // one-cycle pulse every DIV cycles
);

   localparam int unsigned W = $clog2(DIV);
   localparam logic [W-1:0] DIV_LAST = W'(DIV - 1);

   // a divider of one would never release the tick low
   if (DIV < 2) begin : g_chk
      $error("ssw_tick: DIV must be at least 2");
   end

   logic [W-1:0] div_r;      // free-running divider
   logic [W-1:0] div_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // next divider value; wraps at DIV_LAST
   always_comb begin
      div_nxt = (div_r == DIV_LAST) ? '0 : div_r + W'(1);
   end

   // register only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= '0;
      end else begin
         div_r <= div_nxt;
      end
   end

   assign tick = (div_r == DIV_LAST);

endmodule // ssw_tick

// ### core/ssw_top.sv
/*
 * ssw_top: supply supervisor with watchdog, external reset debounce,
 * chip-enable gating, power-fail flag, threshold flag and battery switchover.
 * assumes all inputs but RESET_N synchronous to REF_CLK; the shared reset/strobe line
 * is open drain with an external pull-up resolved outside this module.
 */
// How it works
// - line low at once while supply low
// - hold line low 500 ms after supply returns
// - strobe falling edge restarts watchdog count
// - timeout issues 500 ms reset pulse
// - pulses repeat each timeout until strobed
// - watchdog timeout nominally 700 ms
// - disable input low suppresses watchdog resets
// - accepted external pull yields 500 ms reset
// - threshold flag low when input low, mains up
// - chip enable passes only with good supply
// - chip enable forced high during low supply
// - power-fail flag low while supply below trip
// - supply switch with 20 mV hysteresis
`timescale 1ns/1ps
module ssw_top
   import ssw_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYCLES   // cycles per 1 ms tick
) (
   input  wire logic     REF_CLK,                  // 100 MHz clock
   input  wire logic     RESET_N,                  // async active-low reset
   input  wire ssw_cmp_s CMP_IN,                   // comparator flags
   input  wire logic     WATCHDOG_DISABLE_IN,      // low disables watchdog
   input  wire logic     CHIP_ENABLE_IN_N,         // RAM chip enable request
   input  wire logic     RESET_STROBE_LINE_I,      // line level seen
   output logic          RESET_STROBE_LINE_O,      // driven level, always low
   output logic          RESET_STROBE_LINE_OE,     // high while pulling low
   output logic          GATED_CHIP_ENABLE_OUT_N,  // gated RAM chip enable
   output logic          POWER_FAIL_OUT_N,         // low while supply low
   output logic          THRESHOLD_OUT_N,          // low while input below level, off battery
   output logic          SUPPLY_FROM_BATTERY       // switched supply on battery
);

   ////////////////////////////////////////////////////////////////////////////
   // reset release through two flops
   logic rst_meta_r;         // first stage, read only by the second
   logic rst_n_r;            // reset used everywhere below

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // millisecond tick; every ms figure counts these pulses
   logic tick;               // one-cycle 1 ms enable

   ssw_tick #(
      .DIV   (TICK_DIV)
   ) u_tick (
      .clk   (REF_CLK),
      .rst_n (rst_n_r),
      .tick  (tick)
   );

   // true on the tick that ends a count of last+1 ticks
   function automatic logic cnt_done(input logic [CNT_W-1:0] cnt,
                                     input logic [CNT_W-1:0] last,
                                     input logic             tk);
      return tk && (cnt == last);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // supervisor state
   ssw_state_e       state_r, state_nxt;     // supervisor state
   logic [CNT_W-1:0] ms_cnt_r, ms_cnt_nxt;   // hold, pulse or watchdog count
   logic [CNT_W-1:0] db_cnt_r, db_cnt_nxt;   // external pull debounce count
   logic             line_prev_r, line_prev_nxt; // previous undriven level
   logic             drive;                  // line pulled low by us
   logic             strobe_fall;            // watchdog restart event
   logic             wd_fire;                // watchdog expiry accepted
   logic             ext_fire;               // debounced external pull

   // we pull low on supply loss without waiting for a clock edge
   assign drive = !CMP_IN.vcc_ok || (state_r != SSW_RUN);
   // while we drive, the line reads low and tells nothing
   assign strobe_fall = (state_r == SSW_RUN) && line_prev_r && !RESET_STROBE_LINE_I;
   assign wd_fire  = (state_r == SSW_RUN) && WATCHDOG_DISABLE_IN && !strobe_fall
                     && cnt_done(ms_cnt_r, WD_LAST, tick);
   // shorter pulls are just strobes or bounce, and are ignored
   assign ext_fire = (state_r == SSW_RUN) && !RESET_STROBE_LINE_I
                     && cnt_done(db_cnt_r, PB_LAST, tick);

   // next state and counts
   always_comb begin
      state_nxt     = state_r;
      ms_cnt_nxt    = ms_cnt_r;
      db_cnt_nxt    = db_cnt_r;
      line_prev_nxt = drive ? 1'b1 : RESET_STROBE_LINE_I;
      if (!CMP_IN.vcc_ok) begin
         // supply low: restart the hold from zero on every dip
         state_nxt  = SSW_POR;
         ms_cnt_nxt = CNT_ZERO;
         db_cnt_nxt = CNT_ZERO;
      end else begin
         case (state_r)
            SSW_POR, SSW_PULSE: begin
               // both end after a full 500 ms with the line low
               if (cnt_done(ms_cnt_r, RST_LAST, tick)) begin
                  state_nxt  = SSW_RUN;
                  ms_cnt_nxt = CNT_ZERO;
               end else if (tick) begin
                  ms_cnt_nxt = ms_cnt_r + CNT_W'(1);
               end
               db_cnt_nxt = CNT_ZERO;
            end
            SSW_RUN: begin
               if (ext_fire || wd_fire) begin
                  // back in RUN afterwards with count zero, so silence repeats
                  state_nxt  = SSW_PULSE;
                  ms_cnt_nxt = CNT_ZERO;
               end else if (strobe_fall || !WATCHDOG_DISABLE_IN) begin
                  ms_cnt_nxt = CNT_ZERO;
               end else if (tick && ms_cnt_r != WD_LAST) begin
                  ms_cnt_nxt = ms_cnt_r + CNT_W'(1);
               end
               // debounce counts ticks of continuous low level
               if (RESET_STROBE_LINE_I) begin
                  db_cnt_nxt = CNT_ZERO;
               end else if (tick && !ext_fire) begin
                  db_cnt_nxt = db_cnt_r + CNT_W'(1);
               end else if (ext_fire) begin
                  db_cnt_nxt = CNT_ZERO;
               end
            end
            default: begin
               state_nxt  = SSW_POR;
               ms_cnt_nxt = CNT_ZERO;
            end
         endcase
      end
   end

   // register only
   always_ff @(posedge REF_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r     <= SSW_POR;
         ms_cnt_r    <= CNT_ZERO;
         db_cnt_r    <= CNT_ZERO;
         line_prev_r <= 1'b1;
      end else begin
         state_r     <= state_nxt;
         ms_cnt_r    <= ms_cnt_nxt;
         db_cnt_r    <= db_cnt_nxt;
         line_prev_r <= line_prev_nxt;
      end
   end

   // open drain: only ever pulls low
   assign RESET_STROBE_LINE_O  = 1'b0;
   assign RESET_STROBE_LINE_OE = drive;

   ////////////////////////////////////////////////////////////////////////////
   // side outputs: chip enable, power fail, threshold, switchover
   logic ce_n_r, ce_n_nxt;         // gated chip enable
   logic pf_n_r, pf_n_nxt;         // power-fail flag
   logic thr_n_r, thr_n_nxt;       // threshold flag
   logic batt_r, batt_nxt;         // switched supply on battery

   // next values; one flop delay is well inside the 50 ns gate budget
   always_comb begin
      ce_n_nxt  = !(!CHIP_ENABLE_IN_N && CMP_IN.vcc_ok);
      pf_n_nxt  = CMP_IN.vcc_ok;
      // hysteresis: change only past the far threshold
      batt_nxt  = batt_r;
      if (!batt_r && CMP_IN.vcc_below_lo) begin
         batt_nxt = 1'b1;
      end else if (batt_r && CMP_IN.vcc_above_hi) begin
         batt_nxt = 1'b0;
      end
      // detector off while running from the battery
      thr_n_nxt = !(CMP_IN.tdi_low && !batt_nxt);
   end

   // register only; chip enable and threshold flag reset high, power-fail flag and battery flag low
   always_ff @(posedge REF_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ce_n_r  <= 1'b1;
         pf_n_r  <= 1'b0;
         thr_n_r <= 1'b1;
         batt_r  <= 1'b0;
      end else begin
         ce_n_r  <= ce_n_nxt;
         pf_n_r  <= pf_n_nxt;
         thr_n_r <= thr_n_nxt;
         batt_r  <= batt_nxt;
      end
   end

   assign GATED_CHIP_ENABLE_OUT_N = ce_n_r;
   assign POWER_FAIL_OUT_N        = pf_n_r;
   assign THRESHOLD_OUT_N         = thr_n_r;
   assign SUPPLY_FROM_BATTERY     = batt_r;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!rst_n_r);

   sequence wd_expire_s;
      state_r == SSW_RUN && CMP_IN.vcc_ok && WATCHDOG_DISABLE_IN && tick
      && ms_cnt_r == WD_LAST && !strobe_fall;
   endsequence
   sequence pulse_start_s;
      state_r == SSW_PULSE && ms_cnt_r == CNT_ZERO && RESET_STROBE_LINE_OE;
   endsequence

   supply_drive_a: assert property (!CMP_IN.vcc_ok |-> RESET_STROBE_LINE_OE)
      else $error("line not pulled low while supply low");
   hold_exit_a: assert property ($past(state_r) == SSW_POR && state_r == SSW_RUN
      |-> $past(ms_cnt_r) == RST_LAST && $past(tick))
      else $error("power-on hold ended early");
   strobe_clear_a: assert property (strobe_fall && CMP_IN.vcc_ok && !ext_fire
      |=> ms_cnt_r == CNT_ZERO)
      else $error("strobe did not restart watchdog");
   wd_timeout_a: assert property (wd_expire_s |=> pulse_start_s)
      else $error("timeout gave no reset pulse");
   pulse_len_a: assert property ($past(state_r) == SSW_PULSE && state_r == SSW_RUN
      |-> $past(ms_cnt_r) == RST_LAST && $past(tick) && ms_cnt_r == CNT_ZERO)
      else $error("reset pulse length wrong");
   // a supply dip in the exit cycle rightly keeps the line pulled low
   wd_repeat_a: assert property (state_r == SSW_RUN && $past(state_r) == SSW_PULSE
      && CMP_IN.vcc_ok |-> ms_cnt_r == CNT_ZERO ##0 !RESET_STROBE_LINE_OE)
      else $error("watchdog not rearmed after pulse");
   wd_period_a: assert property (wd_fire |-> ms_cnt_r == WD_LAST && tick)
      else $error("watchdog fired at wrong count");
   wd_disable_a: assert property (!WATCHDOG_DISABLE_IN |-> !wd_fire
      ##1 (ms_cnt_r == CNT_ZERO || state_r != SSW_RUN))
      else $error("watchdog active while disabled");
   ext_accept_a: assert property (ext_fire && CMP_IN.vcc_ok |=> pulse_start_s)
      else $error("external pull not stretched");
   ce_gate_a: assert property (!CMP_IN.vcc_ok |=> GATED_CHIP_ENABLE_OUT_N)
      else $error("chip enable passed during low supply");
   ce_pass_a: assert property (!CHIP_ENABLE_IN_N && CMP_IN.vcc_ok
      |=> !GATED_CHIP_ENABLE_OUT_N)
      else $error("chip enable not passed");
   // the flag flop resets low, not to the supply flag, so skip the first edge after reset
   pf_flag_a: assert property ($past(rst_n_r)
      |-> POWER_FAIL_OUT_N == $past(CMP_IN.vcc_ok))
      else $error("power-fail flag wrong");
   thr_flag_a: assert property (CMP_IN.tdi_low && !batt_r && !CMP_IN.vcc_below_lo
      |=> !THRESHOLD_OUT_N)
      else $error("threshold flag missing");
   batt_hyst_a: assert property (batt_r && !CMP_IN.vcc_above_hi |=> batt_r)
      else $error("switchover chattered");

endmodule // ssw_top

// ### verif/ssw_proc_model.sv
/* ssw_proc_model: processor and pushbutton on the shared reset/strobe line.
   assumes the bench resolves the open-drain line with a pull-up. */
`timescale 1ns/1ps
module ssw_proc_model (
   input  wire logic        clk,        // reference clock
   input  wire logic        strobe_on,  // periodic strobing enabled
   input  wire logic [15:0] gap,        // cycles between strobes
   input  wire logic        push,       // pushbutton held
   output logic             pull        // high while pulling the line low
);
   logic [15:0] cnt_r = 16'h0000;      // cycles since last strobe
   ////////////////////////////////////////////////////////////////////////////
   // strobe period kept short of one timeout by the bench's choice of gap
   always @(posedge clk) begin
      cnt_r <= (strobe_on && cnt_r < gap) ? cnt_r + 16'h0001 : 16'h0000;
   end
   // two-cycle dip per strobe; the button holds as long as the bench asks
   assign pull = push | (strobe_on && cnt_r < 16'h0002);
endmodule // ssw_proc_model

// ### verif/ssw_top_tb_top.sv
/* ssw_top_tb_top: self-checking bench of the supervisor and watchdog.
   assumes a shortened tick of 4 cycles; the line has a pull-up here. */
`timescale 1ns/1ps
module ssw_top_tb_top;
   import ssw_pkg::*;
   localparam int unsigned DIV = 4;  // cycles per ms tick, short for sim
   logic        clk = 1'b0;          // 100 MHz
   logic        rst_n = 1'b0;        // async reset
   ssw_cmp_s    cmp = 4'h8;          // supply good, no battery
   logic        watchdog_disable_in = 1'b1;          // watchdog enabled
   logic        ce_n = 1'b1;         // RAM enable request
   logic        oe, o_n, ce_out_n, pf_n, thr_n, batt;
   logic        strobe_on = 1'b0;    // model strobing
   logic [15:0] gap = 16'h0064;      // strobe spacing
   logic        push = 1'b0;         // pushbutton
   logic        pull;                // model pulling the line
   logic        line;                // resolved line level
   logic [15:0] lfsr_r = 16'h0008;   // random state
   int          err_total = 0;
   int          num_checks = 0;
   int          n;
   ////////////////////////////////////////////////////////////////////////////
   // open drain: anyone pulling wins, else the pull-up
   assign line = !(oe | pull);
   always #5 clk = ~clk;
   ssw_top #(.TICK_DIV(DIV)) dut (
      .REF_CLK(clk), .RESET_N(rst_n), .CMP_IN(cmp), .WATCHDOG_DISABLE_IN(watchdog_disable_in),
      .CHIP_ENABLE_IN_N(ce_n), .RESET_STROBE_LINE_I(line),
      .RESET_STROBE_LINE_O(o_n), .RESET_STROBE_LINE_OE(oe),
      .GATED_CHIP_ENABLE_OUT_N(ce_out_n), .POWER_FAIL_OUT_N(pf_n),
      .THRESHOLD_OUT_N(thr_n), .SUPPLY_FROM_BATTERY(batt));
   ssw_proc_model partner (
      .clk(clk), .strobe_on(strobe_on), .gap(gap), .push(push), .pull(pull));
   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic in_rng(input int v, input int lo, input int hi);
      return (v >= lo) && (v <= hi);
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // bounded wait for the line drive to reach val, n counts cycles
   task automatic wait_oe(input logic val, input int lim, output int cnt);
      cnt = 0;
      while (oe !== val) begin
         @(posedge clk);
         #1;
         cnt++;
         if (cnt > lim) begin
            err_total++;
            print_verdict();
         end
      end
   endtask
   // count cycles the line is driven during a fixed span
   task automatic count_hi(input int span, output int hi);
      hi = 0;
      repeat (span) begin
         @(posedge clk);
         #1;
         if (oe !== 1'b0) hi++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      ssw_cmp_s pv, nv;
      logic     pc, nc, bm;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      wait_oe(1'b0, 3000, n);
      check(in_rng(n, 1990, 2012), 1'b1);
      wait_oe(1'b1, 3000, n);
      check(in_rng(n, 2795, 2808), 1'b1);
      wait_oe(1'b0, 3000, n);
      check(in_rng(n, 1995, 2008), 1'b1);
      wait_oe(1'b1, 3000, n);
      check(in_rng(n, 2795, 2808), 1'b1);
      wait_oe(1'b0, 3000, n);
      // random strobe spacing, always below one timeout
      strobe_on <= 1'b1;
      repeat (6) begin
         lfsr_r = lfsr(lfsr_r);
         gap <= 16'((100 + lfsr_r % 500) * DIV);
         count_hi(3000, n);
         check(n, 0);
      end
      strobe_on <= 1'b0;
      @(posedge clk) watchdog_disable_in <= 1'b0;
      count_hi(4000, n);
      check(n, 0);
      @(posedge clk) watchdog_disable_in <= 1'b1;
      strobe_on <= 1'b1;
      // short pull ignored, long pull stretched
      @(posedge clk) push <= 1'b1;
      repeat (40) @(posedge clk);
      push <= 1'b0;
      count_hi(200, n);
      check(n, 0);
      @(posedge clk) push <= 1'b1;
      wait_oe(1'b1, 200, n);
      check(in_rng(n, 74, 90), 1'b1);
      @(posedge clk) push <= 1'b0;
      wait_oe(1'b0, 3000, n);
      check(in_rng(n, 1990, 2008), 1'b1);
      // supply drop in mid-run
      @(posedge clk) begin
         ce_n <= 1'b0;
         cmp.vcc_ok <= 1'b0;
      end
      #1 check(oe, 1'b1);
      check(o_n, 1'b0);
      @(posedge clk);
      #1;
      check(pf_n, 1'b0);
      check(ce_out_n, 1'b1);
      repeat (50) @(posedge clk);
      cmp.vcc_ok <= 1'b1;
      wait_oe(1'b0, 3000, n);
      check(in_rng(n, 1995, 2008), 1'b1);
      // random side outputs against a bench model
      pv = cmp;
      pc = ce_n;
      bm = 1'b0;
      repeat (400) begin
         lfsr_r = lfsr(lfsr_r);
         nv = ssw_cmp_s'(lfsr_r[3:0]);
         if (nv.vcc_above_hi && nv.vcc_below_lo) nv.vcc_above_hi = 1'b0;
         nc = lfsr_r[7];
         @(posedge clk) begin
            cmp <= nv;
            ce_n <= nc;
         end
         #1;
         if (pv.vcc_below_lo && !bm) bm = 1'b1;
         else if (pv.vcc_above_hi && bm) bm = 1'b0;
         check(ce_out_n, !(!pc && pv.vcc_ok));
         check(pf_n, pv.vcc_ok);
         check(batt, bm);
         check(thr_n, !(pv.tdi_low && !bm));
         pv = nv;
         pc = nc;
      end
      // second reset in mid-run: reset levels, then a fresh power-on hold
      @(posedge clk) begin
         rst_n <= 1'b0;
         cmp <= 4'h8;
         ce_n <= 1'b1;
      end
      repeat (3) @(posedge clk);
      #1;
      check(oe, 1'b1);
      check(ce_out_n, 1'b1);
      check(pf_n, 1'b0);
      check(thr_n, 1'b1);
      check(batt, 1'b0);
      @(posedge clk) rst_n <= 1'b1;
      wait_oe(1'b0, 3000, n);
      check(in_rng(n, 1990, 2012), 1'b1);
      print_verdict();
   end
endmodule // ssw_top_tb_top
